// ===== src/dbg_watch_pkg.sv
package dbg_watch_pkg;
   // register indices on the coprocessor debug port
   localparam logic [3:0]  IDX_WVR0     = 4'h0;
   localparam logic [3:0]  IDX_WCR0     = 4'h4;
   localparam logic [3:0]  IDX_BXVR0    = 4'h8;
   localparam logic [3:0]  IDX_ROM_LO   = 4'hA;
   localparam logic [3:0]  IDX_ROM_HI   = 4'hB;
   localparam logic [3:0]  IDX_OSLAR    = 4'hC;
   localparam logic [3:0]  IDX_OSLSR    = 4'hD;
   localparam int          NUM_WATCH    = 4;
   localparam int          NUM_CTX_BP   = 2;
   localparam int          NUM_BP       = 6;
   // watch_addr_value layout
   localparam logic [31:0] WVR_WMASK    = 32'hFFFF_FFFC;
   // watch_ctrl layout
   localparam logic [31:0] WCR_WMASK    = 32'h1F1F_FFFF;
   localparam int          WCR_MASK_LO  = 24;
   localparam int          WCR_LINK     = 20;
   localparam int          WCR_LINK_IDX_LO = 16;
   localparam int          WCR_SECQ_LO     = 14;
   localparam int          WCR_HYPQ        = 13;
   localparam int          WCR_BYTE_SEL_LO = 5;
   localparam int          WCR_LDST_LO     = 3;
   localparam int          WCR_PRIVQ_LO    = 1;
   localparam int          WCR_EN       = 0;
   localparam logic [31:0] WCR_RST      = 32'h0000_0000;
   // os lock
   localparam logic [31:0] OS_LOCK_KEY  = 32'hC5AC_CE55;
   localparam int          OSLSR_LOCK   = 1;
   localparam logic [31:0] OSLSR_MODEL  = 32'h0000_0008;
   // rom table base
   localparam int          ROM_ADDR_W   = 28;
   localparam logic [1:0]  ROM_VALID    = 2'h3;
   localparam logic [1:0]  ROM_INVALID  = 2'h0;
endpackage

// ===== src/watch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface watch_if;
   logic [31:0] value;
   logic [31:0] ctrl;
   logic        hit;
   modport cfg  (output value, output ctrl, input hit);
   modport unit (input value, input ctrl, output hit);
endinterface
`default_nettype wire

// ===== src/watch_unit.sv
`timescale 1ns/10ps
`default_nettype none
module watch_unit (
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   watch_if.unit            wp,
   input  wire logic        acc_valid_i,
   input  wire logic [31:0] acc_addr_i,
   input  wire logic [7:0]  acc_bytes_i,
   input  wire logic        acc_load_i,
   input  wire logic        acc_store_i,
   input  wire logic        acc_priv_i,
   input  wire logic        acc_ns_i,
   input  wire logic        acc_hyp_i,
   input  wire logic [5:0]  ctx_match_i
);
   typedef struct packed {
      logic hit;
   } unit_state_t;

   unit_state_t st;
   unit_state_t next_st;
   logic [4:0]  msk;
   logic [7:0]  byte_sel;
   logic [1:0]  ldst_sel;
   logic [1:0]  priv_sel;
   logic [1:0]  sec_sel;
   logic [3:0]  link_idx;
   logic [31:0] keep;
   logic [7:0]  watched;
   logic        addr_ok;
   logic        byte_ok;
   logic        type_ok;
   logic        priv_ok;
   logic        sec_ok;
   logic        ctx_ok;

   assign msk = wp.ctrl[dbg_watch_pkg::WCR_MASK_LO +: 5];
   assign byte_sel = wp.ctrl[dbg_watch_pkg::WCR_BYTE_SEL_LO +: 8];
   assign ldst_sel = wp.ctrl[dbg_watch_pkg::WCR_LDST_LO +: 2];
   assign priv_sel = wp.ctrl[dbg_watch_pkg::WCR_PRIVQ_LO +: 2];
   assign sec_sel  = wp.ctrl[dbg_watch_pkg::WCR_SECQ_LO +: 2];
   assign link_idx = wp.ctrl[dbg_watch_pkg::WCR_LINK_IDX_LO +: 4];

   always_comb begin
      // masked low bits drop out of the compare; reserved 1 and 2 act as 0
      keep = (msk < 5'h03) ? 32'hFFFF_FFF8 : ~((32'h1 << msk) - 32'h1);
      addr_ok = (((acc_addr_i ^ wp.value) & keep & 32'hFFFF_FFF8) == 32'h0);
      watched = wp.value[2] ? {byte_sel[3:0], 4'h0} : byte_sel;
      // any touched watched byte hits, whatever the access width
      byte_ok = (msk < 5'h03) ? ((acc_bytes_i & watched) != 8'h00) : (acc_bytes_i != 8'h00);
      type_ok = (ldst_sel[0] & acc_load_i) | (ldst_sel[1] & acc_store_i);
      // privilege of the access itself decides
      if (acc_hyp_i) begin
         priv_ok = priv_sel[0];
      end else begin
         priv_ok = acc_priv_i ? (priv_sel[0] & ~(wp.ctrl[dbg_watch_pkg::WCR_HYPQ] & acc_ns_i))
                              : priv_sel[1];
      end
      case (sec_sel)
         2'h1:    sec_ok = acc_ns_i;
         2'h2:    sec_ok = ~acc_ns_i;
         default: sec_ok = 1'b1;
      endcase
      // indices past the existing pairs never match
      ctx_ok = ~wp.ctrl[dbg_watch_pkg::WCR_LINK]
               | ((link_idx < 4'h6) && ctx_match_i[link_idx[2:0]]);
      next_st.hit = acc_valid_i & wp.ctrl[dbg_watch_pkg::WCR_EN] & addr_ok & byte_ok
                    & type_ok & priv_ok & sec_ok & ctx_ok;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wp.hit = st.hit;

   property p_disabled_quiet;
      @(posedge sys_clk_i) disable iff (srst_i)
      !wp.ctrl[dbg_watch_pkg::WCR_EN] |=> !wp.hit;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pair hit");

   property p_load_only;
      @(posedge sys_clk_i) disable iff (srst_i)
      (wp.ctrl[4:3] == 2'h1) && !acc_load_i |=> !wp.hit;
   endproperty
   a_load_only: assert property (p_load_only) else $error("load-only watch hit a store");

   property p_link_needs_ctx;
      @(posedge sys_clk_i) disable iff (srst_i)
      wp.ctrl[dbg_watch_pkg::WCR_LINK] && (ctx_match_i == 6'h00) |=> !wp.hit;
   endproperty
   a_link_needs_ctx: assert property (p_link_needs_ctx) else $error("linked hit w/o ctx");

   c_hit: cover property (@(posedge sys_clk_i) disable iff (srst_i) wp.hit);
endmodule
`default_nettype wire

// ===== src/dbg_watch_regs.sv
`timescale 1ns/10ps
`default_nettype none
module dbg_watch_regs #(
   parameter logic [27:0] ROM_BASE_ADDR = 28'h0000000,
   parameter bit          ROM_BASE_OK   = 1'b0
) (
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [3:0]  reg_idx_i,
   input  wire logic [31:0] reg_wdata_i,
   output logic [31:0]      reg_rdata_o,
   output logic             reg_rvalid_o,
   input  wire logic        long_desc_i,
   input  wire logic [7:0]  stage2_tag_i,
   input  wire logic        acc_valid_i,
   input  wire logic [31:0] acc_addr_i,
   input  wire logic [7:0]  acc_bytes_i,
   input  wire logic        acc_load_i,
   input  wire logic        acc_store_i,
   input  wire logic        acc_priv_i,
   input  wire logic        acc_ns_i,
   input  wire logic        acc_hyp_i,
   input  wire logic [5:0]  ctx_match_i,
   output logic [3:0]       watch_hit_o,
   output logic [1:0]       vm_match_o,
   output logic             os_lock_o,
   output logic             osr_cnt_clr_o
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0][31:0] wvr;
      logic [3:0][31:0] wcr;
      logic [1:0][7:0]  bxvr;
      logic             lock;
      logic             osr_clr;
      logic [1:0]       vm_match;
      logic [31:0]      rdata;
      logic             rvalid;
   } regs_state_t;

   regs_state_t st;
   regs_state_t next_st;
   logic [1:0]  rom_valid;
   logic [63:0] rom_word;

   // -----------------------------------------------------------------
   // watch pairs
   // -----------------------------------------------------------------
   watch_if wif [dbg_watch_pkg::NUM_WATCH] ();

   genvar g;
   generate
      for (g = 0; g < dbg_watch_pkg::NUM_WATCH; g++) begin : g_pair
         assign wif[g].value = st.wvr[g];
         assign wif[g].ctrl  = st.wcr[g];
         assign watch_hit_o[g] = wif[g].hit;
         watch_unit u_unit (
            .sys_clk_i   (sys_clk_i),
            .srst_i      (srst_i),
            .wp          (wif[g]),
            .acc_valid_i (acc_valid_i),
            .acc_addr_i  (acc_addr_i),
            .acc_bytes_i (acc_bytes_i),
            .acc_load_i  (acc_load_i),
            .acc_store_i (acc_store_i),
            .acc_priv_i  (acc_priv_i),
            .acc_ns_i    (acc_ns_i),
            .acc_hyp_i   (acc_hyp_i),
            .ctx_match_i (ctx_match_i)
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // rom table base image
   // -----------------------------------------------------------------
   always_comb begin
      rom_valid = ROM_BASE_OK ? dbg_watch_pkg::ROM_VALID : dbg_watch_pkg::ROM_INVALID;
      // address field forced to zero while not valid
      rom_word = ROM_BASE_OK ? {24'h000000, ROM_BASE_ADDR, 10'h000, rom_valid}
                             : {62'h0, rom_valid};
   end

   // -----------------------------------------------------------------
   // register access and os lock
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rvalid = reg_rd_i;
      next_st.osr_clr = 1'b0;
      for (int i = 0; i < dbg_watch_pkg::NUM_CTX_BP; i++) begin
         next_st.vm_match[i] = (st.bxvr[i] == stage2_tag_i);
      end
      if (reg_wr_i) begin
         case (reg_idx_i)
            4'h0, 4'h1, 4'h2, 4'h3: begin
               next_st.wvr[reg_idx_i[1:0]] = reg_wdata_i & dbg_watch_pkg::WVR_WMASK;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
               next_st.wcr[reg_idx_i[1:0]] = reg_wdata_i & dbg_watch_pkg::WCR_WMASK;
            end
            4'h8, 4'h9: begin
               next_st.bxvr[reg_idx_i[0]] = reg_wdata_i[7:0];
            end
            dbg_watch_pkg::IDX_OSLAR: begin
               if (reg_wdata_i == dbg_watch_pkg::OS_LOCK_KEY) begin
                  next_st.lock = 1'b1;
                  next_st.osr_clr = 1'b1;
               end else begin
                  next_st.lock = 1'b0;
               end
            end
            default: begin
               next_st.lock = st.lock;
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_idx_i)
            4'h0, 4'h1, 4'h2, 4'h3: next_st.rdata = st.wvr[reg_idx_i[1:0]];
            4'h4, 4'h5, 4'h6, 4'h7: next_st.rdata = st.wcr[reg_idx_i[1:0]];
            4'h8, 4'h9: next_st.rdata = {24'h000000, st.bxvr[reg_idx_i[0]]};
            dbg_watch_pkg::IDX_ROM_LO: next_st.rdata = rom_word[31:0];
            // upper word exists only under the long format
            dbg_watch_pkg::IDX_ROM_HI: next_st.rdata = long_desc_i ? rom_word[63:32] : 32'h0;
            dbg_watch_pkg::IDX_OSLSR: begin
               next_st.rdata = dbg_watch_pkg::OSLSR_MODEL
                               | ({31'h0, st.lock} << dbg_watch_pkg::OSLSR_LOCK);
            end
            default: next_st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_o   = st.rdata;
   assign reg_rvalid_o  = st.rvalid;
   assign os_lock_o     = st.lock;
   assign osr_cnt_clr_o = st.osr_clr;
   assign vm_match_o    = st.vm_match;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_wvr_low_zero;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && (reg_idx_i < dbg_watch_pkg::IDX_WCR0) |=> reg_rvalid_o && reg_rdata_o[1:0] == 2'h0;
   endproperty
   a_wvr_low_zero: assert property (p_wvr_low_zero) else $error("wvr low bits set");

   property p_wvr_back;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_WVR0 ##1 !reg_wr_i
      ##1 reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_WVR0 && !reg_wr_i
      |=> reg_rdata_o[31:2] == $past(reg_wdata_i[31:2], 3);
   endproperty
   a_wvr_back: assert property (p_wvr_back) else $error("wvr readback wrong");

   property p_wcr_resv;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i[3:2] == 2'h1 |=> reg_rdata_o[31:29] == 3'h0 && reg_rdata_o[23:21] == 3'h0;
   endproperty
   a_wcr_resv: assert property (p_wcr_resv) else $error("wcr reserved bits set");

   property p_lock_key;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_OSLAR && reg_wdata_i == dbg_watch_pkg::OS_LOCK_KEY
      |=> os_lock_o && osr_cnt_clr_o ##1 !osr_cnt_clr_o;
   endproperty
   a_lock_key: assert property (p_lock_key) else $error("key did not lock");

   property p_unlock;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_OSLAR && reg_wdata_i != dbg_watch_pkg::OS_LOCK_KEY
      |=> !os_lock_o && !osr_cnt_clr_o;
   endproperty
   a_unlock: assert property (p_unlock) else $error("other value did not unlock");

   property p_lock_flag;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_OSLSR |=> reg_rdata_o[1] == $past(os_lock_o);
   endproperty
   a_lock_flag: assert property (p_lock_flag) else $error("lock flag mismatch");

   property p_rom_valid;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_ROM_LO
      |=> reg_rdata_o[1:0] == (ROM_BASE_OK ? 2'h3 : 2'h0);
   endproperty
   a_rom_valid: assert property (p_rom_valid) else $error("rom valid wrong");

   property p_rom_short;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_ROM_HI && !long_desc_i |=> reg_rdata_o == 32'h0;
   endproperty
   a_rom_short: assert property (p_rom_short) else $error("rom high word in short format");

   property p_vm_tag;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_BXVR0
      ##1 stage2_tag_i == $past(reg_wdata_i[7:0]) |=> vm_match_o[0];
   endproperty
   a_vm_tag: assert property (p_vm_tag) else $error("vm tag no match");

   property p_vm_miss;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == 4'h9
      ##1 !reg_wr_i && stage2_tag_i != $past(reg_wdata_i[7:0]) |=> !vm_match_o[1];
   endproperty
   a_vm_miss: assert property (p_vm_miss) else $error("vm tag false match");

   property p_wcr_back;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_WCR0 ##1 !reg_wr_i
      ##1 reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_WCR0 && !reg_wr_i
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & dbg_watch_pkg::WCR_WMASK);
   endproperty
   a_wcr_back: assert property (p_wcr_back) else $error("wcr readback wrong");

   property p_bxvr_back;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_BXVR0 ##1 !reg_wr_i
      ##1 reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_BXVR0 && !reg_wr_i
      |=> reg_rdata_o == {24'h000000, $past(reg_wdata_i[7:0], 3)};
   endproperty
   a_bxvr_back: assert property (p_bxvr_back) else $error("tag readback wrong");

   property p_bxvr_upper;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i[3:1] == 3'h4 |=> reg_rdata_o[31:8] == 24'h000000;
   endproperty
   a_bxvr_upper: assert property (p_bxvr_upper) else $error("tag upper bits set");

   property p_unused_zero;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i > dbg_watch_pkg::IDX_OSLSR |=> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused index not zero");

   property p_rom_lo_addr;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_ROM_LO
      |=> reg_rdata_o[31:12] == (ROM_BASE_OK ? ROM_BASE_ADDR[19:0] : 20'h00000)
          && reg_rdata_o[11:2] == 10'h000;
   endproperty
   a_rom_lo_addr: assert property (p_rom_lo_addr) else $error("rom low word wrong");

   property p_rom_hi_long;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_ROM_HI && long_desc_i
      |=> reg_rdata_o == (ROM_BASE_OK ? {24'h000000, ROM_BASE_ADDR[27:20]} : 32'h0000_0000);
   endproperty
   a_rom_hi_long: assert property (p_rom_hi_long) else $error("rom high word wrong");

   property p_lock_hold;
      @(posedge sys_clk_i) disable iff (srst_i)
      !(reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_OSLAR) |=> os_lock_o == $past(os_lock_o);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock moved w/o write");

   property p_clr_only_key;
      @(posedge sys_clk_i) disable iff (srst_i)
      !(reg_wr_i && reg_idx_i == dbg_watch_pkg::IDX_OSLAR
        && reg_wdata_i == dbg_watch_pkg::OS_LOCK_KEY) |=> !osr_cnt_clr_o;
   endproperty
   a_clr_only_key: assert property (p_clr_only_key) else $error("counter clear w/o key");

   property p_oslsr_fixed;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_OSLSR
      |=> reg_rdata_o[31:2] == 30'h0000_0002 && !reg_rdata_o[0];
   endproperty
   a_oslsr_fixed: assert property (p_oslsr_fixed) else $error("lock status bits wrong");

   property p_rvalid_on;
      @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i |=> reg_rvalid_o;
   endproperty
   a_rvalid_on: assert property (p_rvalid_on) else $error("read not answered");

   property p_rvalid_off;
      @(posedge sys_clk_i) disable iff (srst_i)
      !reg_rd_i |=> !reg_rvalid_o;
   endproperty
   a_rvalid_off: assert property (p_rvalid_off) else $error("stray read valid");

   property p_rdata_hold;
      @(posedge sys_clk_i) disable iff (srst_i)
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_no_acc_quiet;
      @(posedge sys_clk_i) disable iff (srst_i)
      !acc_valid_i |=> watch_hit_o == 4'h0;
   endproperty
   a_no_acc_quiet: assert property (p_no_acc_quiet) else $error("hit w/o access");

   property p_no_byte_quiet;
      @(posedge sys_clk_i) disable iff (srst_i)
      acc_bytes_i == 8'h00 |=> watch_hit_o == 4'h0;
   endproperty
   a_no_byte_quiet: assert property (p_no_byte_quiet) else $error("hit w/o bytes");

   property p_no_type_quiet;
      @(posedge sys_clk_i) disable iff (srst_i)
      !acc_load_i && !acc_store_i |=> watch_hit_o == 4'h0;
   endproperty
   a_no_type_quiet: assert property (p_no_type_quiet) else $error("hit w/o type");

   c_lock: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(os_lock_o));
   c_unlock: cover property (@(posedge sys_clk_i) disable iff (srst_i) $fell(os_lock_o));
   c_rom_rd: cover property (@(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && reg_idx_i == dbg_watch_pkg::IDX_ROM_HI && long_desc_i);
   c_any_hit: cover property (@(posedge sys_clk_i) disable iff (srst_i) watch_hit_o != 4'h0);
endmodule
`default_nettype wire

// ===== sim/dbg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dbg_host_model (
   input  wire logic        sys_clk_i,
   input  wire logic [31:0] reg_rdata_i,
   input  wire logic        reg_rvalid_i,
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   output logic [3:0]       reg_idx_o,
   output logic [31:0]      reg_wdata_o
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_idx_o = 4'hF;
      reg_wdata_o = 32'h0000_0000;
   end
   // released lines show the inverse of the last value
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      @(posedge sys_clk_i);
      #1;
      reg_wr_o = 1'b1;
      reg_idx_o = idx;
      reg_wdata_o = d;
      @(posedge sys_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_idx_o = ~idx;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic v);
      @(posedge sys_clk_i);
      #1;
      reg_rd_o = 1'b1;
      reg_idx_o = idx;
      @(posedge sys_clk_i);
      #1;
      reg_rd_o = 1'b0;
      reg_idx_o = ~idx;
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_debug_watchpoint_lock_regs.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_debug_watchpoint_lock_regs;
   localparam logic [27:0] ROM_A = 28'hABC_DE12;
   logic        sys_clk_i, srst_i, reg_wr, reg_rd, reg_rvalid, long_desc, acc_valid;
   logic        acc_load, acc_store, acc_priv, acc_ns, acc_hyp, os_lock, clr, v;
   logic [3:0]  reg_idx, watch_hit;
   logic [31:0] reg_wdata, reg_rdata, acc_addr, d;
   logic [7:0]  stage2_tag, acc_bytes;
   logic [5:0]  ctx_match;
   logic [1:0]  vm_match;
   int          err_count, checked, cycles;
   dbg_watch_regs #(.ROM_BASE_ADDR(ROM_A), .ROM_BASE_OK(1'b1)) DUT (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_idx_i(reg_idx), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .reg_rvalid_o(reg_rvalid), .long_desc_i(long_desc), .stage2_tag_i(stage2_tag),
      .acc_valid_i(acc_valid), .acc_addr_i(acc_addr), .acc_bytes_i(acc_bytes),
      .acc_load_i(acc_load), .acc_store_i(acc_store), .acc_priv_i(acc_priv),
      .acc_ns_i(acc_ns), .acc_hyp_i(acc_hyp), .ctx_match_i(ctx_match),
      .watch_hit_o(watch_hit), .vm_match_o(vm_match), .os_lock_o(os_lock),
      .osr_cnt_clr_o(clr));
   dbg_host_model host (
      .sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_idx_o(reg_idx), .reg_wdata_o(reg_wdata));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end
   function automatic logic [31:0] wcr(input logic [4:0] m, input logic lk,
         input logic [3:0] li, input logic [1:0] sq, input logic [7:0] bs,
         input logic [1:0] ls, input logic [1:0] pq, input logic en);
      return {3'h0, m, 3'h0, lk, li, sq, 1'b0, bs, ls, pq, en};
   endfunction
   task automatic chk_rd(input logic [3:0] idx, input logic [31:0] exp);
      host.rd(idx, d, v);
      `CHK(v, 1'b1)
      `CHK(d, exp)
   endtask
   // q = {load, store, priv, ns, hyp}
   task automatic acc(input logic [31:0] a, input logic [7:0] b, input logic [4:0] q,
         input logic [3:0] e);
      @(posedge sys_clk_i);
      #1;
      acc_valid = 1'b1;
      acc_addr = a;
      acc_bytes = b;
      {acc_load, acc_store, acc_priv, acc_ns, acc_hyp} = q;
      @(posedge sys_clk_i);
      #1;
      acc_valid = 1'b0;
      acc_addr = ~a;
      `CHK(watch_hit, e)
   endtask
   task automatic t_regs();
      for (int n = 0; n < 4; n++) chk_rd(4'(n) + 4'h4, 32'h0000_0000);
      host.wr(4'h4, 32'hFFFF_FFFF);
      chk_rd(4'h4, dbg_watch_pkg::WCR_WMASK);
      host.wr(4'h0, 32'hFFFF_FFFF);
      chk_rd(4'h0, 32'hFFFF_FFFC);
      host.wr(4'h8, 32'hFFFF_FF5A);
      chk_rd(4'h8, 32'h0000_005A);
      host.wr(4'h9, 32'h0000_0033);
      repeat (2) @(posedge sys_clk_i);
      #1;
      `CHK(vm_match, 2'h1)
      chk_rd(4'hE, 32'h0000_0000);
      for (int n = 0; n < 4; n++) host.wr(4'(n) + 4'h4, 32'h0000_0000);
   endtask
   task automatic t_lock();
      host.wr(4'hC, dbg_watch_pkg::OS_LOCK_KEY);
      `CHK({os_lock, clr}, 2'h3)
      @(posedge sys_clk_i);
      #1;
      `CHK(clr, 1'b0)
      chk_rd(4'hD, 32'h0000_000A);
      host.wr(4'hC, 32'hC5AC_CE54);
      `CHK({os_lock, clr}, 2'h0)
      chk_rd(4'hD, 32'h0000_0008);
   endtask
   task automatic t_rom();
      host.wr(4'hA, 32'h0000_0000);
      chk_rd(4'hA, {ROM_A[19:0], 10'h000, 2'h3});
      chk_rd(4'hB, {24'h00_0000, ROM_A[27:20]});
      long_desc = 1'b0;
      chk_rd(4'hB, 32'h0000_0000);
   endtask
   task automatic t_watch();
      for (int n = 0; n < 4; n++) begin
         host.wr(4'(n), 32'h2000_1000 + 32'(n) * 32'h100);
         host.wr(4'(n) + 4'h4, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'hFF, 2'h3, 2'h3, 1'b1));
         acc(32'h2000_1000 + 32'(n) * 32'h100, 8'h01, 5'h16, 4'h1 << n);
         host.wr(4'(n) + 4'h4, 32'h0000_0000);
      end
      host.wr(4'h1, 32'h2000_1000);
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h0F, 2'h3, 2'h3, 1'b1));
      acc(32'h2000_1000, 8'h08, 5'h16, 4'h2);
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h0);
      acc(32'h2000_1008, 8'h01, 5'h16, 4'h0);
      host.wr(4'h1, 32'h2000_1004);
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h01, 2'h3, 2'h3, 1'b1));
      acc(32'h2000_1000, 8'hF0, 5'h16, 4'h2);
      acc(32'h2000_1000, 8'h0F, 5'h16, 4'h0);
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h01, 2'h3, 2'h3, 1'b0));
      acc(32'h2000_1000, 8'hFF, 5'h16, 4'h0);
      for (int l = 1; l < 4; l++) begin
         host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h01, 2'(l), 2'h3, 1'b1));
         for (int t = 1; t < 4; t++)
            acc(32'h2000_1000, 8'h10, {t[0], t[1], 3'b110}, {2'h0, |(l & t), 1'b0});
      end
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h01, 2'h3, 2'h1, 1'b1));
      acc(32'h2000_1000, 8'h10, 5'h12, 4'h0);
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h2);
      acc(32'h2000_1000, 8'h10, 5'h17, 4'h2);
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h1, 8'h01, 2'h3, 2'h3, 1'b1));
      acc(32'h2000_1000, 8'h10, 5'h14, 4'h0);
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h2);
      host.wr(4'h5, wcr(5'h0, 1'b0, 4'h0, 2'h0, 8'h01, 2'h3, 2'h3, 1'b1) | 32'h0000_2000);
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h0);
      acc(32'h2000_1000, 8'h10, 5'h17, 4'h2);
      host.wr(4'h5, wcr(5'h0, 1'b1, 4'h2, 2'h0, 8'h01, 2'h3, 2'h3, 1'b1));
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h0);
      ctx_match = 6'h04;
      acc(32'h2000_1000, 8'h10, 5'h16, 4'h2);
      host.wr(4'h1, 32'h2000_1000);
      host.wr(4'h5, wcr(5'h05, 1'b0, 4'h0, 2'h0, 8'hFF, 2'h3, 2'h3, 1'b1));
      acc(32'h2000_1018, 8'h80, 5'h16, 4'h2);
      acc(32'h2000_1020, 8'h01, 5'h16, 4'h0);
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      srst_i = 1'b1;
      long_desc = 1'b1;
      stage2_tag = 8'h5A;
      acc_valid = 1'b0;
      acc_addr = 32'h0000_0000;
      acc_bytes = 8'h00;
      {acc_load, acc_store, acc_priv, acc_ns, acc_hyp} = 5'h00;
      ctx_match = 6'h00;
      repeat (12) @(posedge sys_clk_i);
      #1;
      srst_i = 1'b0;
      t_regs();
      t_lock();
      t_rom();
      t_watch();
      stop_test();
   end
endmodule
`default_nettype wire
